// File: dv/rbc_core_model.sv
// Purpose: core model facing the reset outputs
// Assumes: sleep requested by the bench
// Notes: a core in reset cannot sleep
`timescale 1ns/10ps
module rbc_core_model (
   // clock
   input wire logic clk_sys_in,
   // from the block
   input wire logic core_reset_in,
   input wire logic exec_hold_in,
   // from the bench
   input wire logic sleep_req_in,
   // to the block and bench
   output logic sleep_out,
   output logic [15:0] run_cnt_out
);
   always_ff @(posedge clk_sys_in)
      sleep_out <= sleep_req_in && !core_reset_in;
   // executes only when out of reset and not held on wake
   always_ff @(posedge clk_sys_in)
      if (core_reset_in)
         run_cnt_out <= 16'h0000;
      else if (!exec_hold_in && !sleep_out)
         run_cnt_out <= run_cnt_out + 16'h0001;
endmodule : rbc_core_model

// File: dv/rbc_monitor.sv
// Purpose: port checker for rbc_top
// Assumes: FILTER_CYCLES equals the design's value
// Notes: sees ports only; register contents are checked by the bench
`timescale 1ns/10ps
module rbc_monitor #(parameter int FILTER_CYCLES = 200) (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   // inputs watched
   input wire logic [1:0] bor_mode_sel_in,
   input wire logic bor_level_sel_in,
   input wire logic por_ok_in,
   input wire logic supply_low_in,
   input wire logic bor_circuit_ready_in,
   input wire logic sleep_in,
   input wire rbc_pkg::rbc_src_t reset_src_in,
   input wire logic psel_in,
   input wire logic penable_in,
   // outputs watched
   input wire logic pready_out,
   input wire logic pslverr_out,
   input wire logic core_reset_out,
   input wire logic bor_level_out,
   input wire logic bor_circuit_en_out
);
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);
   logic [15:0] low_cnt;
   ////////////////////////////////////////
   // only counts where protection is surely on, so sleep needs no care
   always_ff @(posedge clk_sys_in)
      if (!rst_n_in || !supply_low_in || !bor_circuit_ready_in || bor_mode_sel_in != 2'h3)
         low_cnt <= 16'h0000;
      else if (low_cnt != 16'hFFFF)
         low_cnt <= low_cnt + 16'h0001;
   sequence s_setup;
      psel_in && !penable_in;
   endsequence
   a_apb_answer: assert property (s_setup |=> pready_out) else $error("no answer");
   a_pready_pulse: assert property (pready_out |=> !pready_out) else $error("long pready");
   a_err_with_ready: assert property (pslverr_out |-> pready_out) else $error("stray error");
   a_por_hold: assert property (!por_ok_in [*3] |-> core_reset_out) else $error("por");
   a_src_hold: assert property ((reset_src_in != '0) [*3] |-> core_reset_out)
      else $error("source reset missed");
   a_bor_trip: assert property (low_cnt > FILTER_CYCLES + 6 |-> core_reset_out)
      else $error("brown-out missed");
   a_mode_on: assert property (bor_mode_sel_in == 2'h3 [*3] |-> bor_circuit_en_out)
      else $error("mode on");
   a_mode_off: assert property (bor_mode_sel_in == 2'h0 [*3] |-> !bor_circuit_en_out)
      else $error("mode off");
   a_sleep_off: assert property ((bor_mode_sel_in == 2'h2 && sleep_in) [*3]
      |-> !bor_circuit_en_out) else $error("sleep off");
   a_level_copy: assert property ($stable(bor_level_sel_in) [*3]
      |-> bor_level_out == bor_level_sel_in) else $error("level");
   a_clean_release: assert property ($fell(core_reset_out)
      |-> $past(por_ok_in) && $past(reset_src_in) == '0) else $error("early release");
endmodule : rbc_monitor
bind rbc_top rbc_monitor #(.FILTER_CYCLES(FILTER_CYCLES)) rbc_monitor_i (.*);

// File: dv/testbench.sv
// Purpose: self-checking bench for rbc_top
// Assumes: POWERUP_TIMER_CYCLES 20, FILTER_CYCLES 8
// Notes: seed 18; inputs and checks both at rising edges, checks see settled values
`timescale 1ns/10ps
module testbench;
   logic clk_sys_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic [1:0] mode = 2'h3;
   logic lvl = 1'b0, powerup_timer_en = 1'b0, por_ok = 1'b0, low = 1'b0, rdy = 1'b1, low_power_brownout = 1'b0;
   logic slp_req = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, er, a_irq;
   logic [11:0] pa = 12'h000;
   logic [31:0] pwd = 32'h00000000, prd, rd, w;
   rbc_pkg::rbc_src_t src = '0;
   logic pready, perr, crst, hold, lvl_o, en, irq, slp;
   logic [15:0] run;
   logic [1:0] wm [3] = '{2'h2, 2'h3, 2'h1};
   int checked = 0, fail_count = 0;
   rbc_top #(.POWERUP_TIMER_CYCLES(20), .FILTER_CYCLES(8)) rbc_top_i (.clk_sys_in(clk_sys_in),
      .rst_n_in(rst_n_in), .bor_mode_sel_in(mode), .bor_level_sel_in(lvl),
      .powerup_timer_en_in(powerup_timer_en), .por_ok_in(por_ok), .supply_low_in(low),
      .bor_circuit_ready_in(rdy), .low_power_brownout_in(low_power_brownout), .sleep_in(slp),
      .reset_src_in(src), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa),
      .pwdata_in(pwd), .prdata_out(prd), .pready_out(pready), .pslverr_out(perr),
      .core_reset_out(crst), .exec_hold_out(hold), .bor_level_out(lvl_o),
      .bor_circuit_en_out(en), .irq_out(irq));
   rbc_core_model rbc_core_model_i (.clk_sys_in(clk_sys_in), .core_reset_in(crst),
      .exec_hold_in(hold), .sleep_req_in(slp_req), .sleep_out(slp), .run_cnt_out(run));
   ////////////////////////////////////////
   initial forever #2.5 clk_sys_in = ~clk_sys_in;
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      checked++;
      if (s !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   // ends on a rising edge so the next input change is a non-blocking one there
   task automatic st(input int n);
      repeat (n) @(posedge clk_sys_in);
   endtask : st
   // holds the request until pready is seen high at a rising edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys_in);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= wr;
      pa <= a;
      pwd <= d;
      @(posedge clk_sys_in);
      pen <= 1'b1;
      // pready, read data and error are taken at the same rising edge
      do @(posedge clk_sys_in); while (pready !== 1'b1);
      rd = prd;
      er = perr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask : apb
   function automatic logic exp_en(input logic [1:0] m, input logic s, input logic sw);
      return m == 2'h3 || (m == 2'h2 && !s) || (m == 2'h1 && sw);
   endfunction : exp_en
   task automatic report_and_stop();
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : report_and_stop
   initial begin
      #200000;
      fail_count++;
      report_and_stop();
   end
   initial begin
      void'($urandom(18));
      repeat (16) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      st(1);
      chk("held at start", 1, crst);
      @(posedge clk_sys_in);
      por_ok <= 1'b1;
      powerup_timer_en <= 1'b1;
      st(12);
      chk("timer hold", 1, crst);
      st(30);
      chk("released", 0, crst);
      apb(1'b0, 12'h0FC, 32'h0);
      chk("unmapped err", 1, er);
      chk("unmapped data", 0, rd);
      apb(1'b0, 12'h004, 32'h0);
      chk("bor flag idle", 1, rd[0]);
      $display("test power_on done");
      for (int i = 0; i < 8; i++) begin
         w = $urandom;
         apb(1'b1, 12'h000, w);
         apb(1'b0, 12'h000, 32'h0);
         chk("sw enable", w[0], rd[0]);
         chk("ready flag", rdy, rd[1]);
         @(posedge clk_sys_in);
         mode <= i[2:1];
         slp_req <= i[0];
         lvl <= w[1];
         st(5);
         chk("protect en", exp_en(i[2:1], i[0], w[0]), en);
         chk("level", w[1], lvl_o);
      end
      @(posedge clk_sys_in);
      slp_req <= 1'b0;
      mode <= 2'h3;
      low <= 1'b1;
      st(5);
      @(posedge clk_sys_in);
      low <= 1'b0;
      st(4);
      chk("short dip", 0, crst);
      @(posedge clk_sys_in);
      low <= 1'b1;
      st(16);
      chk("brown-out", 1, crst);
      apb(1'b0, 12'h004, 32'h0);
      chk("bor flag", 0, rd[0]);
      apb(1'b0, 12'h00C, 32'h0);
      chk("irq bor", 1, rd[2]);
      low <= 1'b0;
      st(40);
      apb(1'b1, 12'h010, 32'h0);
      st(2);
      a_irq = irq;
      apb(1'b1, 12'h010, 32'h7);
      st(2);
      chk("irq mask", 1, a_irq ^ irq);
      apb(1'b1, 12'h00C, 32'h7);
      st(2);
      chk("irq clear", 0, irq);
      $display("test brown_out done");
      apb(1'b1, 12'h000, 32'h1);
      mode <= 2'h0;
      low <= 1'b1;
      st(20);
      chk("mode off", 0, crst);
      low <= 1'b0;
      low_power_brownout <= 1'b1;
      st(4);
      chk("low power bor", 1, crst);
      low_power_brownout <= 1'b0;
      st(40);
      for (int k = 0; k < 6; k++) begin
         @(posedge clk_sys_in);
         src <= rbc_pkg::rbc_src_t'(6'h01 << k);
         st(4);
         chk("source reset", 1, crst);
         src <= '0;
         st(40);
         chk("source release", 0, crst);
      end
      apb(1'b1, 12'h000, 32'h0);
      for (int k = 0; k < 3; k++) begin
         mode <= wm[k];
         slp_req <= 1'b1;
         st(4);
         rdy <= 1'b0;
         slp_req <= 1'b0;
         st(4);
         chk("wake hold", wm[k] == 2'h2, hold);
         rdy <= 1'b1;
         st(6);
         chk("wake go", 0, hold);
      end
      chk("core ran", 1, run != 16'h0000);
      $display("test wake done");
      report_and_stop();
   end
endmodule : testbench

// File: verilog/rbc_map.svh
// Purpose: constants for the reset and brown-out control block
// Assumes: 200 MHz system clock, registers on APB with 32-bit data
// Notes: offsets are byte addresses
`ifndef RBC_MAP_SVH
`define RBC_MAP_SVH
`define RBC_ADDR_CONTROL 12'h000
`define RBC_ADDR_CAUSE 12'h004
`define RBC_ADDR_STATUS 12'h008
`define RBC_ADDR_IRQ_STAT 12'h00C
`define RBC_ADDR_IRQ_MASK 12'h010
`define RBC_MODE_ON 2'h3
`define RBC_MODE_NOSLEEP 2'h2
`define RBC_MODE_SW 2'h1
`define RBC_MODE_OFF 2'h0
`define RBC_CAUSE_RESET 8'hFF
`define RBC_POWERUP_TIMER_MS 64
`define RBC_CLK_MHZ 200
`define RBC_FILTER_NS 1000
`define RBC_CLK_NS 5
`endif

// File: verilog/rbc_pkg.sv
// Purpose: types for the reset and brown-out control block
// Assumes: included map header holds the numbers
// Notes: cause bits 0 to 4 are active low, cleared by the event; bits 5 and 6 are set to 1 by theirs
package rbc_pkg;
   typedef enum logic [1:0] {RBC_HOLD, RBC_TIMER, RBC_WAIT, RBC_RUN} rbc_state_t;
   typedef struct packed {
      logic stack_underflow;
      logic stack_overflow;
      logic watchdog;
      logic master_clear_pin;
      logic reset_instr;
      logic prog_exit;
   } rbc_src_t;
   typedef struct packed {
      logic brownout;
      logic core_release;
      logic bor_ready;
   } rbc_irq_t;
endpackage : rbc_pkg

// File: verilog/rbc_top.sv
// Purpose: reset combiner, power-up timer and brown-out mode control
// Assumes: comparator and detector inputs are synchronous to clk_sys_in
// Notes: registers on APB, zero wait states
//
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/10ps
`include "rbc_map.svh"
module rbc_top #(
   parameter int POWERUP_TIMER_CYCLES = `RBC_POWERUP_TIMER_MS * 1000 * 1000 / `RBC_CLK_NS,
   parameter int FILTER_CYCLES = (`RBC_FILTER_NS + `RBC_CLK_NS - 1) / `RBC_CLK_NS
) (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   // configuration and analog status
   input wire logic [1:0] bor_mode_sel_in,
   input wire logic bor_level_sel_in,
   input wire logic powerup_timer_en_in,
   input wire logic por_ok_in,
   input wire logic supply_low_in,
   input wire logic bor_circuit_ready_in,
   input wire logic low_power_brownout_in,
   input wire logic sleep_in,
   input wire rbc_pkg::rbc_src_t reset_src_in,
   // apb
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // outputs
   output logic core_reset_out,
   output logic exec_hold_out,
   output logic bor_level_out,
   output logic bor_circuit_en_out,
   output logic irq_out
);
   // counters are 32 bits wide and need at least one cycle to count
   if (POWERUP_TIMER_CYCLES < 1 || FILTER_CYCLES < 1) begin : g_bad_counts
      $error("rbc_top: counts must be positive");
   end
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic protect_on(input logic [1:0] mode, input logic sw, input logic slp);
      unique case (mode)
         `RBC_MODE_ON: protect_on = 1'b1;
         `RBC_MODE_NOSLEEP: protect_on = !slp;
         `RBC_MODE_SW: protect_on = sw;
         `RBC_MODE_OFF: protect_on = 1'b0;
      endcase
   endfunction : protect_on
   ////////////////////////////////////////////////////////////////////////////
   logic sw_bor_enable_reg;
   logic [7:0] reset_cause_reg;
   rbc_pkg::rbc_irq_t irq_stat_reg, irq_mask_reg, irq_ev;
   rbc_pkg::rbc_state_t state_reg;
   logic [31:0] powerup_timer_cnt_reg, filt_cnt_reg;
   logic bor_trip_reg, bor_ready_flag_reg, from_power_reg, rel_meta_reg;
   logic sleep_d_reg, waking;
   logic prot, brownout, src_any, wr, rd;
   assign prot = protect_on(bor_mode_sel_in, sw_bor_enable_reg, sleep_in)
                 && bor_circuit_ready_in;
   assign brownout = bor_trip_reg || low_power_brownout_in;
   assign src_any = |reset_src_in;
   assign wr = psel_in && penable_in && pwrite_in;
   assign rd = psel_in && !penable_in && !pwrite_in;
   assign waking = sleep_d_reg && !sleep_in;
   ////////////////////////////////////////////////////////////////////////////
   // noise filter: only a low supply lasting past the filter time trips
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         filt_cnt_reg <= 32'h0000_0000;
         bor_trip_reg <= 1'b0;
      end else if (prot && supply_low_in) begin
         if (filt_cnt_reg >= 32'(FILTER_CYCLES)) begin
            bor_trip_reg <= 1'b1;
         end else begin
            filt_cnt_reg <= filt_cnt_reg + 32'h0000_0001;
         end
      end else begin
         filt_cnt_reg <= 32'h0000_0000;
         bor_trip_reg <= 1'b0;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // release sequencer: hold, optional power-up timer, brown-out wait, run
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         state_reg <= rbc_pkg::RBC_HOLD;
         powerup_timer_cnt_reg <= 32'h0000_0000;
         from_power_reg <= 1'b1;
      end else if (!por_ok_in || brownout) begin
         state_reg <= rbc_pkg::RBC_HOLD;
         powerup_timer_cnt_reg <= 32'h0000_0000;
         from_power_reg <= 1'b1;
      end else begin
         unique case (state_reg)
            rbc_pkg::RBC_HOLD: begin
               // timer starts only once power-on and brown-out are released
               if (from_power_reg && powerup_timer_en_in) begin
                  state_reg <= rbc_pkg::RBC_TIMER;
               end else if (!src_any) begin
                  state_reg <= rbc_pkg::RBC_WAIT;
               end
            end
            rbc_pkg::RBC_TIMER: begin
               if (powerup_timer_cnt_reg >= 32'(POWERUP_TIMER_CYCLES - 1)) begin
                  state_reg <= rbc_pkg::RBC_WAIT;
               end else begin
                  powerup_timer_cnt_reg <= powerup_timer_cnt_reg + 32'h0000_0001;
               end
            end
            rbc_pkg::RBC_WAIT: begin
               if (src_any) begin
                  state_reg <= rbc_pkg::RBC_HOLD;
               end else if (bor_mode_sel_in == `RBC_MODE_OFF ||
                            (bor_mode_sel_in == `RBC_MODE_SW && !sw_bor_enable_reg) ||
                            (bor_circuit_ready_in && !supply_low_in)) begin
                  state_reg <= rbc_pkg::RBC_RUN;
                  from_power_reg <= 1'b0;
               end
            end
            rbc_pkg::RBC_RUN: begin
               if (src_any) begin
                  state_reg <= rbc_pkg::RBC_HOLD;
                  powerup_timer_cnt_reg <= 32'h0000_0000;
               end
            end
         endcase
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // wake hold: modes 10 and 01 (enabled or from power-up) wait for ready and supply; 11 does not
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         sleep_d_reg <= 1'b0;
         exec_hold_out <= 1'b0;
      end else begin
         sleep_d_reg <= sleep_in;
         if (waking && (bor_mode_sel_in == `RBC_MODE_NOSLEEP ||
                        (bor_mode_sel_in == `RBC_MODE_SW &&
                         (sw_bor_enable_reg || from_power_reg)))) begin
            exec_hold_out <= 1'b1;
         end else if (bor_circuit_ready_in && !supply_low_in) begin
            exec_hold_out <= 1'b0;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // two-stage release so the core leaves reset on a clean edge
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         rel_meta_reg <= 1'b0;
         core_reset_out <= 1'b1;
      end else begin
         rel_meta_reg <= (state_reg == rbc_pkg::RBC_RUN) && !brownout && por_ok_in;
         core_reset_out <= !(rel_meta_reg && state_reg == rbc_pkg::RBC_RUN
                             && !brownout && por_ok_in);
      end
   end
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         bor_level_out <= 1'b0;
         bor_circuit_en_out <= 1'b0;
         bor_ready_flag_reg <= 1'b0;
      end else begin
         bor_level_out <= bor_level_sel_in;
         bor_circuit_en_out <= protect_on(bor_mode_sel_in, sw_bor_enable_reg, sleep_in);
         bor_ready_flag_reg <= bor_circuit_ready_in;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // registers; the block reset loads every cause bit with 1 (8'hFF)
   assign irq_ev.brownout = brownout;
   assign irq_ev.core_release = core_reset_out && !(rel_meta_reg && state_reg == rbc_pkg::RBC_RUN
                                                    && !brownout && por_ok_in) ? 1'b0 :
                                core_reset_out;
   assign irq_ev.bor_ready = bor_circuit_ready_in && !bor_ready_flag_reg;
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         sw_bor_enable_reg <= 1'b0;
         reset_cause_reg <= `RBC_CAUSE_RESET;
         irq_stat_reg <= '0;
         irq_mask_reg <= '0;
      end else begin
         if (wr && paddr_in == `RBC_ADDR_CONTROL) sw_bor_enable_reg <= pwdata_in[0];
         if (wr && paddr_in == `RBC_ADDR_IRQ_MASK) irq_mask_reg <= pwdata_in[2:0];
         // event set wins over a write-one clear in the same cycle
         irq_stat_reg <= (irq_stat_reg & ~((wr && paddr_in == `RBC_ADDR_IRQ_STAT) ?
                          pwdata_in[2:0] : 3'h0)) | irq_ev;
         if (wr && paddr_in == `RBC_ADDR_CAUSE) reset_cause_reg <= pwdata_in[7:0];
         reset_cause_reg[0] <= (wr && paddr_in == `RBC_ADDR_CAUSE) ? pwdata_in[0] :
                               reset_cause_reg[0];
         if (brownout) reset_cause_reg[0] <= 1'b0;
         if (!por_ok_in) reset_cause_reg[1] <= 1'b0;
         if (reset_src_in.master_clear_pin) reset_cause_reg[2] <= 1'b0;
         if (reset_src_in.reset_instr) reset_cause_reg[3] <= 1'b0;
         if (reset_src_in.watchdog) reset_cause_reg[4] <= 1'b0;
         if (reset_src_in.stack_overflow) reset_cause_reg[5] <= 1'b1;
         if (reset_src_in.stack_underflow) reset_cause_reg[6] <= 1'b1;
      end
   end
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         prdata_out <= 32'h0000_0000;
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
         irq_out <= 1'b0;
      end else begin
         pready_out <= psel_in && !penable_in;
         pslverr_out <= psel_in && !penable_in && !(paddr_in == `RBC_ADDR_CONTROL ||
            paddr_in == `RBC_ADDR_CAUSE || paddr_in == `RBC_ADDR_STATUS ||
            paddr_in == `RBC_ADDR_IRQ_STAT || paddr_in == `RBC_ADDR_IRQ_MASK);
         irq_out <= |(irq_stat_reg & irq_mask_reg);
         if (rd) begin
            unique case (paddr_in)
               `RBC_ADDR_CONTROL: prdata_out <= {30'h0, bor_ready_flag_reg, sw_bor_enable_reg};
               `RBC_ADDR_CAUSE: prdata_out <= {24'h0, reset_cause_reg};
               `RBC_ADDR_STATUS: prdata_out <= {28'h0, exec_hold_out, core_reset_out, state_reg};
               `RBC_ADDR_IRQ_STAT: prdata_out <= {29'h0, irq_stat_reg};
               `RBC_ADDR_IRQ_MASK: prdata_out <= {29'h0, irq_mask_reg};
               default: prdata_out <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule : rbc_top
